// [rtl/tpc_map.vh]
// Purpose: register map and field layout of the six-channel pwm timer
// Assumes: classic wishbone, 32-bit data, word-aligned registers
// Notes:   offsets are byte addresses
`ifndef TPC_MAP_VH
`define TPC_MAP_VH
`define TPC_ADDR_W        8
`define TPC_OFF_CTRL      8'h00
`define TPC_OFF_COUNT     8'h04
`define TPC_OFF_PERIOD    8'h08
`define TPC_OFF_CH_BASE   8'h10
`define TPC_OFF_CH_STEP   8'h08
`define TPC_OFF_CH_LAST   8'h3C
`define TPC_NCH           6
// timer control/status fields
`define TPC_CT_DIV_LO     0
`define TPC_CT_DIV_HI     2
`define TPC_CT_RESET_BIT  4
`define TPC_CT_HALT_BIT   5
`define TPC_CT_WIRQEN_BIT 6
`define TPC_CT_WRAP_BIT   7
`define TPC_DIV_EXT       3'h7
`define TPC_CTRL_RST_DIV  3'h0
// channel control/status fields
`define TPC_CC_FULL_BIT   0
`define TPC_CC_TOW_BIT    1
`define TPC_CC_ACT_LO     2
`define TPC_CC_ACT_HI     3
`define TPC_CC_SINGLE_BIT 4
`define TPC_CC_PAIR_BIT   5
`define TPC_CC_IRQEN_BIT  6
`define TPC_CC_FLAG_BIT   7
`define TPC_CC_W          8
`define TPC_ACT_CLEAR     2'h2
`define TPC_ACT_SET       2'h3
`define TPC_ACT_TOGGLE    2'h1
`define TPC_MODE_UNBUF    2'h1
`define TPC_MODE_BUF      2'h2
`define TPC_CNT_W         16
`define TPC_ZERO16        16'h0000
`define TPC_ONES16        16'hFFFF
`define TPC_ZERO32        32'h0000_0000
`define TPC_PS_MAX        6'h3F
`endif

// [rtl/tpc_prescale.v]
// Purpose: counter tick source for the pwm timer
// Assumes: ext_clk_in synchronous to core_clk
// Notes:   one tick per selected divided clock or external rising edge
`timescale 1ns/10ps
`include "tpc_map.vh"
module tpc_prescale (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // control
  input  wire        clear,
  input  wire [2:0]  div_sel,
  input  wire        ext_clk_in,
  // tick
  output reg         tick_reg
);
  reg  [5:0] div_reg;
  reg        ext_reg;
  reg        tick_next;
  wire [5:0] div_mask;

  // mask of low bits that must all be ones for the selected divide
  assign div_mask = ~(`TPC_PS_MAX << div_sel);

  always @*
  begin
    if (div_sel == `TPC_DIV_EXT)
      tick_next = ext_clk_in & ~ext_reg;
    else
      tick_next = ((div_reg & div_mask) == div_mask);
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_reg  <= 6'h00;
      ext_reg  <= 1'b0;
      tick_reg <= 1'b0;
    end
    else
    begin
      ext_reg <= ext_clk_in;
      if (clear)
      begin
        div_reg  <= 6'h00;
        tick_reg <= 1'b0;
      end
      else
      begin
        div_reg  <= div_reg + 6'h01;
        tick_reg <= tick_next;
      end
    end
  end
endmodule // tpc_prescale

// [rtl/tpc_top.v]
// Purpose: six-channel 16-bit pwm timer with wishbone register access
// Assumes: single clock core_clk, async active-high rst
// Notes:   event flags clear by writing 0 after a read that saw them set
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "tpc_map.vh"
module tpc_top (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // external count clock
  input  wire        external_count_clock_pin,
  // channel pins and pin ownership
  output reg  [5:0]  chan_pin_out,
  output reg  [5:0]  chan_pin_oe,
  // interrupt requests
  output reg         wrap_irq,
  output reg  [5:0]  chan_irq
);
  // timer control
  reg  [2:0]  clock_divide_select_reg;
  reg         counter_halt_reg;
  reg         wrap_irq_enable_reg;
  reg         wrap_flag_reg;
  reg         wrap_seen_reg;
  reg  [15:0] count_reg;
  reg  [15:0] period_limit_reg;
  reg         ctr_clear_reg;
  // channels
  reg  [15:0] channel_compare_value [0:5];
  reg  [7:0]  channel_control_status [0:5];
  reg  [5:0]  flag_seen_reg;
  reg  [5:0]  pin_reg;
  reg  [2:0]  pair_sel_reg;   // 1 selects odd compare
  reg  [2:0]  pair_pend_reg;
  reg  [2:0]  pair_last_reg;  // compare written last
  wire        tick;
  wire        wrap_now;
  wire        acc;
  wire        wr;
  wire [2:0]  ch_idx;
  wire        ch_hit;
  wire [15:0] count_step;
  reg  [31:0] rd_data;
  reg  [5:0]  match_now;
  reg  [5:0]  pin_next;
  reg  [5:0]  oe_next;
  integer     i;
  integer     j;
  integer     k;

  // channel index of a channel address
  function [2:0] ch_of;
    input [7:0] adr;
    reg   [7:0] rel;
    begin
      rel   = adr - `TPC_OFF_CH_BASE;
      ch_of = rel[5:3];
    end
  endfunction

  // effective mode: pair select outranks single select
  function linked;
    input [7:0] cs;
    begin
      linked = cs[`TPC_CC_PAIR_BIT];
    end
  endfunction

  tpc_prescale u_pre (
    .core_clk   (core_clk),
    .rst        (rst),
    .clear      (ctr_clear_reg),
    .div_sel    (clock_divide_select_reg),
    .ext_clk_in (external_count_clock_pin),
    .tick_reg   (tick)
  );

  assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr       = acc & wb_we_i & wb_sel_i[0];
  assign ch_idx   = ch_of(wb_adr_i);
  assign ch_hit   = (wb_adr_i >= `TPC_OFF_CH_BASE) &&
                    (wb_adr_i <= `TPC_OFF_CH_LAST) &&
                    (wb_adr_i[1:0] == 2'b00);
  assign wrap_now = tick & ~counter_halt_reg &
                    (count_reg == period_limit_reg);
  // count taken at this tick; matching on it puts the match on the same
  // edge as its count, so the pulse spans exactly wrap to match
  assign count_step = wrap_now ? `TPC_ZERO16 : count_reg + 16'h0001;

  // compare match per channel; linked pairs use the selected compare
  always @*
  begin
    match_now = 6'h00;
    for (j = 0; j < `TPC_NCH; j = j + 1)
    begin
      if ((j % 2 == 0) && linked(channel_control_status[j]))
        match_now[j] = tick & ~counter_halt_reg &
          (count_step == channel_compare_value[j + pair_sel_reg[j / 2]]);
      else
        match_now[j] = tick & ~counter_halt_reg &
          (count_step == channel_compare_value[j]);
    end
  end

  // pin behaviour: full without wrap toggle forces high, else toggle on wrap, else match action
  always @*
  begin
    pin_next = pin_reg;
    oe_next  = 6'h00;
    for (k = 0; k < `TPC_NCH; k = k + 1)
    begin
      if ((k % 2 == 1) && linked(channel_control_status[k - 1]))
        oe_next[k] = 1'b0;
      else if ((linked(channel_control_status[k]) && (k % 2 == 0)) ||
               channel_control_status[k][`TPC_CC_SINGLE_BIT])
      begin
        oe_next[k] = 1'b1;
        if (channel_control_status[k][`TPC_CC_FULL_BIT] &&
            !channel_control_status[k][`TPC_CC_TOW_BIT])
          pin_next[k] = 1'b1;
        else if (wrap_now && channel_control_status[k][`TPC_CC_TOW_BIT])
          pin_next[k] = ~pin_reg[k];
        else if (match_now[k])
        begin
          // no toggle at wraps when cleared: matches then clear, set, toggle or hold the pin
          case (channel_control_status[k][`TPC_CC_ACT_HI:`TPC_CC_ACT_LO])
            `TPC_ACT_CLEAR:  pin_next[k] = 1'b0;
            `TPC_ACT_SET:    pin_next[k] = 1'b1;
            `TPC_ACT_TOGGLE: pin_next[k] = ~pin_reg[k];
            default:         pin_next[k] = pin_reg[k];
          endcase
        end
      end
    end
  end

  // read mux
  always @*
  begin
    rd_data = `TPC_ZERO32;
    if (wb_adr_i == `TPC_OFF_CTRL)
    begin
      rd_data[`TPC_CT_DIV_HI:`TPC_CT_DIV_LO] = clock_divide_select_reg;
      rd_data[`TPC_CT_HALT_BIT] = counter_halt_reg;
      rd_data[`TPC_CT_WIRQEN_BIT] = wrap_irq_enable_reg;
      rd_data[`TPC_CT_WRAP_BIT] = wrap_flag_reg;
    end
    else if (wb_adr_i == `TPC_OFF_COUNT)
      rd_data[15:0] = count_reg;
    else if (wb_adr_i == `TPC_OFF_PERIOD)
      rd_data[15:0] = period_limit_reg;
    else if (ch_hit && !wb_adr_i[2])
      rd_data[7:0] = channel_control_status[ch_idx];
    else if (ch_hit)
      rd_data[15:0] = channel_compare_value[ch_idx];
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      clock_divide_select_reg <= `TPC_CTRL_RST_DIV;
      counter_halt_reg        <= 1'b1;
      wrap_irq_enable_reg     <= 1'b0;
      wrap_flag_reg           <= 1'b0;
      wrap_seen_reg           <= 1'b0;
      count_reg               <= `TPC_ZERO16;
      period_limit_reg        <= `TPC_ONES16;
      ctr_clear_reg           <= 1'b0;
      flag_seen_reg           <= 6'h00;
      pin_reg                 <= 6'h00;
      pair_sel_reg            <= 3'h0;
      pair_pend_reg           <= 3'h0;
      pair_last_reg           <= 3'h0;
      wb_ack_o                <= 1'b0;
      wb_dat_o                <= `TPC_ZERO32;
      chan_pin_out            <= 6'h00;
      chan_pin_oe             <= 6'h00;
      wrap_irq                <= 1'b0;
      chan_irq                <= 6'h00;
      for (i = 0; i < `TPC_NCH; i = i + 1)
      begin
        channel_compare_value[i]  <= `TPC_ZERO16;
        channel_control_status[i] <= 8'h00;
      end
    end
    else
    begin
      wb_ack_o      <= acc;
      wb_dat_o      <= acc ? rd_data : `TPC_ZERO32;
      ctr_clear_reg <= wr && (wb_adr_i == `TPC_OFF_CTRL) &&
                       wb_dat_i[`TPC_CT_RESET_BIT];
      // counter
      if (ctr_clear_reg)
        count_reg <= `TPC_ZERO16;
      else if (wrap_now)
        count_reg <= `TPC_ZERO16;
      else if (tick && !counter_halt_reg)
        count_reg <= count_reg + 16'h0001;
      // linked pair hand-over at the wrap
      for (i = 0; i < 3; i = i + 1)
      begin
        if (wrap_now && pair_pend_reg[i])
        begin
          pair_sel_reg[i]  <= pair_last_reg[i];
          pair_pend_reg[i] <= 1'b0;
        end
        if (!linked(channel_control_status[2 * i]))
        begin
          pair_sel_reg[i]  <= 1'b0;
          pair_pend_reg[i] <= 1'b0;
        end
      end
      // read of a status register arms the clear
      if (acc && !wb_we_i && wb_adr_i == `TPC_OFF_CTRL)
        wrap_seen_reg <= wrap_flag_reg;
      if (acc && !wb_we_i && ch_hit && !wb_adr_i[2])
        flag_seen_reg[ch_idx] <=
          channel_control_status[ch_idx][`TPC_CC_FLAG_BIT];
      // register writes
      if (wr && wb_adr_i == `TPC_OFF_CTRL)
      begin
        clock_divide_select_reg <=
          wb_dat_i[`TPC_CT_DIV_HI:`TPC_CT_DIV_LO];
        counter_halt_reg        <= wb_dat_i[`TPC_CT_HALT_BIT];
        wrap_irq_enable_reg     <= wb_dat_i[`TPC_CT_WIRQEN_BIT];
        if (!wb_dat_i[`TPC_CT_WRAP_BIT] && wrap_seen_reg)
        begin
          wrap_flag_reg <= 1'b0;
          wrap_seen_reg <= 1'b0;
        end
      end
      if (wr && wb_adr_i == `TPC_OFF_PERIOD && wb_sel_i[1])
        period_limit_reg <= wb_dat_i[15:0];
      for (i = 0; i < `TPC_NCH; i = i + 1)
      begin
        if (wr && ch_hit && ch_idx == i && !wb_adr_i[2])
        begin
          channel_control_status[i][6:0] <= wb_dat_i[6:0];
          if (!wb_dat_i[`TPC_CC_FLAG_BIT] && flag_seen_reg[i])
          begin
            channel_control_status[i][7] <= 1'b0;
            flag_seen_reg[i] <= 1'b0;
          end
        end
        if (wr && ch_hit && ch_idx == i && wb_adr_i[2] && wb_sel_i[1])
        begin
          channel_compare_value[i] <= wb_dat_i[15:0];
          if (i % 2 == 1)
          begin
            pair_last_reg[i / 2] <= 1'b1;
            pair_pend_reg[i / 2] <= 1'b1;
          end
          else
          begin
            pair_last_reg[i / 2] <= 1'b0;
            pair_pend_reg[i / 2] <= 1'b1;
          end
        end
        // hardware set wins over clear
        if (match_now[i])
          channel_control_status[i][`TPC_CC_FLAG_BIT] <= 1'b1;
      end
      if (wrap_now)
        wrap_flag_reg <= 1'b1;
      pin_reg      <= pin_next;
      chan_pin_out <= pin_next;
      chan_pin_oe  <= oe_next;
      wrap_irq     <= wrap_flag_reg & wrap_irq_enable_reg;
      for (i = 0; i < `TPC_NCH; i = i + 1)
        chan_irq[i] <= channel_control_status[i][`TPC_CC_FLAG_BIT] &
                       channel_control_status[i][`TPC_CC_IRQEN_BIT];
    end
  end
endmodule // tpc_top

// [sim/tpc_chk.sv]
// Purpose: bus and pin checks on the pwm timer ports
// Assumes: sees tpc_top ports only
// Notes:   since_wr counts cycles since the last write request
`timescale 1ns/10ps
module tpc_chk (
  // clock and reset
  input wire        core_clk,
  input wire        rst,
  // bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // pins and requests
  input wire [5:0]  chan_pin_oe,
  input wire        wrap_irq,
  input wire [5:0]  chan_irq
);
  reg [2:0] since_wr_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always @(posedge core_clk or posedge rst)
    if (rst)
      since_wr_reg <= 3'h7;
    else if (wb_cyc_i && wb_stb_i && wb_we_i)
      since_wr_reg <= 3'h0;
    else if (since_wr_reg != 3'h7)
      since_wr_reg <= since_wr_reg + 3'h1;
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("ack missing after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_no_req;
    !(wb_cyc_i && wb_stb_i) ##1 !(wb_cyc_i && wb_stb_i) |-> !wb_ack_o;
  endproperty
  a_no_req: assert property (p_no_req)
    else $error("ack while idle");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  property p_oe_cause;
    $changed(chan_pin_oe) |-> since_wr_reg <= 3'h3;
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("pin ownership changed without write");
  property p_cirq_fall;
    ($past(chan_irq) & ~chan_irq) != 6'h00 |-> since_wr_reg <= 3'h3;
  endproperty
  a_cirq_fall: assert property (p_cirq_fall)
    else $error("channel request dropped without write");
  property p_wirq_fall;
    $fell(wrap_irq) |-> since_wr_reg <= 3'h3;
  endproperty
  a_wirq_fall: assert property (p_wirq_fall)
    else $error("wrap request dropped without write");
endmodule // tpc_chk
bind tpc_top tpc_chk i_tpc_chk (.core_clk(core_clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_pin_oe(chan_pin_oe),
  .wrap_irq(wrap_irq), .chan_irq(chan_irq));

// [sim/tpc_load.sv]
// Purpose: load on one channel pin, measures period and high time
// Assumes: pin pulled low when not driven
// Notes:   figures update at each rising edge of the pin
`timescale 1ns/10ps
module tpc_load (
  // clock and reset
  input wire         core_clk,
  input wire         rst,
  // pins
  input wire  [5:0]  pin_out,
  input wire  [5:0]  pin_oe,
  input wire  [2:0]  sel,
  // measurements
  output logic [15:0] hi_len,
  output logic [15:0] per_len
);
  logic [15:0] run, hrun;
  logic        lvl, prev;
  assign lvl = pin_oe[sel] ? pin_out[sel] : 1'b0;
  always @(posedge core_clk or posedge rst)
    if (rst)
    begin
      {run, hrun, hi_len, per_len, prev} <= '0;
    end
    else
    begin
      prev <= lvl;
      if (lvl && !prev)
      begin
        per_len <= run;
        hi_len <= hrun;
        run <= 16'h0001;
        hrun <= 16'h0001;
      end
      else
      begin
        run <= run + 16'h0001;
        hrun <= hrun + {15'h0000, lvl};
      end
    end
endmodule // tpc_load

// [sim/tb_tpc_top.sv]
// Purpose: self-checking bench for the pwm timer
// Assumes: undivided tick unless set, period limit 255
// Notes:   external count clock toggled only in the divide scenario
`timescale 1ns/10ps
module tb_tpc_top;
  logic        core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, ext_clk;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        wb_ack_o, wrap_irq;
  logic [5:0]  chan_pin_out, chan_pin_oe, chan_irq;
  logic [2:0]  sel;
  logic [15:0] hi_len, per_len;
  int          error_cnt, checks, h, n;
  tpc_top i_tpc_top (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .external_count_clock_pin(ext_clk),
    .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
    .wrap_irq(wrap_irq), .chan_irq(chan_irq));
  tpc_load i_tpc_load (.core_clk(core_clk), .rst(rst),
    .pin_out(chan_pin_out), .pin_oe(chan_pin_oe), .sel(sel),
    .hi_len(hi_len), .per_len(per_len));
  initial
  begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  task report_and_stop;
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hF};
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    chk(n < 20, 1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task cnt_hi(input int ch, input int c);
    h = 0;
    repeat (c) @(negedge core_clk) h += (chan_pin_out[ch] & chan_pin_oe[ch]);
  endtask
  task t_reset;
    wb(0, 8'h00, 0);
    chk(rd, 32'h0000_0020);
    wb(0, 8'h08, 0);
    chk(rd, 32'h0000_FFFF);
    wb(0, 8'hFC, 0);
    chk(rd, 32'h0000_0000);
  endtask
  task t_pwm;
    wb(1, 8'h00, 32'h0000_0030);
    wb(1, 8'h08, 32'h0000_00FF);
    wb(1, 8'h14, 32'h0000_0080);
    wb(1, 8'h10, 32'h0000_001A);
    wb(1, 8'h00, 32'h0000_0000);
    repeat (800) @(posedge core_clk);
    chk(per_len, 256);
    chk(hi_len, 128);
    @(negedge chan_pin_out[0]);
    wb(1, 8'h14, 32'h0000_0040);
    repeat (800) @(posedge core_clk);
    chk(hi_len, 64);
    wb(1, 8'h10, 32'h0000_001E);
    repeat (800) @(posedge core_clk);
    chk(hi_len, 192);
  endtask
  task t_zero_full;
    wb(1, 8'h10, 32'h0000_0018);
    repeat (300) @(posedge core_clk);
    cnt_hi(0, 300);
    chk(h, 0);
    wb(1, 8'h10, 32'h0000_0019);
    repeat (5) @(posedge core_clk);
    cnt_hi(0, 300);
    chk(h, 300);
  endtask
  task t_toggle;
    sel = 2;
    wb(1, 8'h20, 32'h0000_0012);
    repeat (1100) @(posedge core_clk);
    chk(per_len, 512);
    chk(hi_len, 256);
  endtask
  task t_pair;
    wb(1, 8'h24, 32'h0000_0040);
    wb(1, 8'h20, 32'h0000_003A);
    repeat (3) @(posedge core_clk);
    chk(chan_pin_oe[3:2], 2'b01);
    repeat (800) @(posedge core_clk);
    chk(hi_len, 64);
    wb(1, 8'h2C, 32'h0000_00C0);
    repeat (800) @(posedge core_clk);
    chk(hi_len, 192);
    wb(1, 8'h24, 32'h0000_0020);
    repeat (800) @(posedge core_clk);
    chk(hi_len, 32);
  endtask
  task t_irq;
    wb(1, 8'h10, 32'h0000_005A);
    for (n = 0; chan_irq[0] !== 1'b1 && n < 600; n++) @(posedge core_clk);
    @(negedge chan_pin_out[0]);
    wb(0, 8'h10, 0);
    chk(rd[7], 1);
    wb(1, 8'h10, 32'h0000_005A);
    repeat (2) @(posedge core_clk);
    chk(chan_irq[0], 0);
    wb(1, 8'h00, 32'h0000_0040);
    for (n = 0; wrap_irq !== 1'b1 && n < 600; n++) @(posedge core_clk);
    @(posedge chan_pin_out[0]);
    wb(1, 8'h14, 32'h0000_0080);
    wb(0, 8'h00, 0);
    chk(rd[7], 1);
    wb(1, 8'h00, 32'h0000_0040);
    repeat (2) @(posedge core_clk);
    chk(wrap_irq, 0);
  endtask
  task t_div;
    sel = 0;
    for (int k = 1; k < 3; k++)
    begin
      wb(1, 8'h00, k);
      repeat (800 << k) @(posedge core_clk);
      chk(per_len, 256 << k);
      chk(hi_len, 128 << k);
    end
    wb(1, 8'h00, 32'h0000_0007);
    repeat (1600) @(posedge core_clk) ext_clk <= ~ext_clk;
    chk(per_len, 512);
    chk(hi_len, 256);
  endtask
  initial
  begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b1000;
    {wb_adr_i, wb_sel_i, wb_dat_i, sel, ext_clk} = '0;
    {error_cnt, checks} = 0;
    repeat (5) @(posedge core_clk);
    rst <= 0;
    t_reset;
    t_pwm;
    t_zero_full;
    t_toggle;
    t_pair;
    sel = 0;
    t_irq;
    t_div;
    report_and_stop;
  end
  initial
  begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    report_and_stop;
  end
endmodule // tb_tpc_top
